// ---- dv/fbp_frame_buffer_pixel_packer_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbp_checker (
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  input wire logic [5:0]  cfg_bpp_in,
  input wire logic [11:0] cfg_width_in,
  input wire logic [11:0] cfg_height_in,
  input wire logic        req_valid_in,
  input wire logic        req_write_in,
  input wire logic [11:0] req_x_in,
  input wire logic [11:0] req_y_in,
  input wire logic [31:0] req_color_in,
  input wire logic        req_ready_out,
  input wire logic        rsp_valid_out,
  input wire logic        rsp_error_out,
  input wire logic [31:0] line_stride_out,
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [7:0]  mem_wdata_out,
  input wire logic        mem_ack_in
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic bad_bpp;
  // depth outside the accepted list
  assign bad_bpp = !(cfg_bpp_in inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h18, 6'h20});
  sequence s_take;
    req_valid_in && req_ready_out;
  endsequence
  sequence s_take16w;
    s_take ##0 (req_write_in && cfg_bpp_in == 6'h10 && req_x_in < cfg_width_in
                && req_y_in < cfg_height_in);
  endsequence
  a_rsp_one_cycle: assert property (rsp_valid_out |=> !rsp_valid_out)
    else $error("response longer than one cycle");
  a_ready_returns: assert property (rsp_valid_out |=> req_ready_out)
    else $error("ready not back after response");
  a_busy_after_take: assert property (s_take |=> !req_ready_out)
    else $error("ready high while request outstanding");
  a_error_in_rsp: assert property (rsp_error_out |-> rsp_valid_out)
    else $error("error flag outside response");
  a_bad_depth: assert property (
    s_take ##0 bad_bpp |=> rsp_valid_out && rsp_error_out && !mem_req_out)
    else $error("unsupported depth not refused");
  a_mem_hold: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
    && $stable(mem_addr_out) && $stable(mem_we_out) && $stable(mem_wdata_out))
    else $error("memory request changed before ack");
  a_beat_ascend: assert property (
    (mem_req_out && mem_ack_in && mem_we_out) ##1 (mem_req_out && mem_we_out)
    |-> mem_addr_out == $past(mem_addr_out) + 32'h1)
    else $error("write beats not at ascending addresses");
  a_low_byte_first: assert property (
    s_take16w |=> mem_req_out && mem_we_out && mem_wdata_out == $past(req_color_in[7:0]))
    else $error("first written byte is not the low byte");
  a_stride_value: assert property (
    s_take16w |=> line_stride_out == {19'h0, $past(cfg_width_in), 1'b0})
    else $error("line stride wrong at two bytes per pixel");
endmodule : fbp_checker
bind fbp_frame_buffer_pixel_packer fbp_checker chk_i (.ref_clk_in, .sys_rst_in, .cfg_bpp_in,
  .cfg_width_in, .cfg_height_in, .req_valid_in, .req_write_in, .req_x_in, .req_y_in,
  .req_color_in, .req_ready_out, .rsp_valid_out, .rsp_error_out, .line_stride_out,
  .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in);
`default_nettype wire

// ---- dv/fbp_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbp_mem_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        slow_in,
  output logic             ack_out,
  output logic [7:0]       rdata_out
);
  logic [7:0] mem_r [0:255];
  logic [1:0] wait_r;
  logic [7:0] last_r;
  // a beat completes at once, or after two waiting cycles when slow
  assign ack_out = req_in && (!slow_in || wait_r == 2'h2);
  // idle data line shows the inverse of the last byte, so stale data cannot pass
  assign rdata_out = (ack_out && !we_in) ? mem_r[addr_in[7:0]] : ~last_r;
  // seeded contents make every untouched byte distinct
  initial for (int i = 0; i < 256; i++) mem_r[i] = 8'(i) ^ 8'h5a;
  // wait counter and storage; only the low address byte is decoded
  always @(posedge clk_in) begin
    if (rst_in || ack_out) wait_r <= 2'h0;
    else if (req_in) wait_r <= wait_r + 2'h1;
    if (ack_out && we_in) mem_r[addr_in[7:0]] <= wdata_in;
    if (rst_in) last_r <= 8'h00;
    else if (ack_out && !we_in) last_r <= mem_r[addr_in[7:0]];
  end
endmodule : fbp_mem_model
`default_nettype wire

// ---- dv/test_frame_buffer_pixel_packer.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_frame_buffer_pixel_packer;
  logic ref_clk_in = 0, sys_rst_in = 1, pixel_packing_order_in = 0, buffer_scan_order_in = 0;
  logic req_valid_in = 0, req_write_in = 0, slow = 0;
  logic [5:0]  cfg_bpp_in = 6'h08;
  logic [31:0] cfg_base_in = 32'h10, req_color_in = 32'h0;
  logic [11:0] cfg_width_in = 12'h5, cfg_height_in = 12'h4, req_x_in = 12'h0, req_y_in = 12'h0;
  logic req_ready_out, rsp_valid_out, rsp_error_out, mem_req_out, mem_we_out;
  logic [31:0] rsp_color_out, line_stride_out, mem_addr_out;
  logic [7:0] mem_wdata_out;
  wire logic mem_ack_in;
  wire logic [7:0] mem_rdata_in;
  int num_errors = 0, checks = 0;
  fbp_frame_buffer_pixel_packer uut (.ref_clk_in, .sys_rst_in, .cfg_bpp_in,
    .pixel_packing_order_in, .buffer_scan_order_in, .cfg_base_in, .cfg_width_in,
    .cfg_height_in, .req_valid_in, .req_write_in, .req_x_in, .req_y_in, .req_color_in,
    .req_ready_out, .rsp_valid_out, .rsp_error_out, .rsp_color_out, .line_stride_out,
    .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in);
  fbp_mem_model mem (.clk_in(ref_clk_in), .rst_in(sys_rst_in), .req_in(mem_req_out),
    .we_in(mem_we_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
    .slow_in(slow), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
  // free-running 100 MHz clock
  initial forever #5 ref_clk_in = ~ref_clk_in;
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task results;
    $display("checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // one request, held until taken; a hung response ends the run
  task do_req(input logic w, input logic [11:0] x, input logic [11:0] y,
              input logic [31:0] c, output logic [31:0] rc, output logic er);
    int n;
    req_valid_in <= 1'b1; req_write_in <= w; req_x_in <= x; req_y_in <= y; req_color_in <= c;
    n = 0;
    do begin @(posedge ref_clk_in); n++; end while (req_ready_out !== 1'b1 && n < 50);
    if (req_ready_out !== 1'b1) begin num_errors++; results; end
    req_valid_in <= 1'b0;
    do begin @(posedge ref_clk_in); n++; end while (rsp_valid_out !== 1'b1 && n < 100);
    if (rsp_valid_out !== 1'b1) begin num_errors++; results; end
    rc = rsp_color_out;
    er = rsp_error_out;
  endtask : do_req
  // wide depths: pixel (2,3) in a 5-wide frame, slow memory on odd passes
  task t_wide;
    logic [31:0] rc, a, c; logic er; logic [7:0] nxt; int b;
    c = 32'h44332211;
    for (int i = 0; i < 4; i++) begin
      b = i + 1;
      cfg_bpp_in <= 6'(8 * b); slow <= i[0];
      a = 32'h10 + 32'(17 * b);
      nxt = mem.mem_r[8'(a + 32'(b))];
      do_req(1'b1, 12'h2, 12'h3, c, rc, er);
      chk("write error flag", 32'h0, 32'(er));
      chk("write answer color", 32'h0, rc);
      for (int k = 0; k < b; k++) chk("wide byte", 32'(c[8*k +: 8]), 32'(mem.mem_r[8'(a + 32'(k))]));
      chk("byte after pixel", 32'(nxt), 32'(mem.mem_r[8'(a + 32'(b))]));
      chk("stride", 32'(5 * b), line_stride_out);
      do_req(1'b0, 12'h2, 12'h3, 32'h0, rc, er);
      chk("wide read", c & 32'((64'h1 << (8 * b)) - 64'h1), rc);
    end
  endtask : t_wide
  // narrow depths, all packing and scan pairs, odd frame size forces padding
  task t_narrow;
    logic [31:0] rc, a, c; logic er; logic [7:0] e; int bp, ppb, pkc, oth, sh, s;
    cfg_base_in <= 32'h40;
    for (int i = 0; i < 12; i++) begin
      bp = 1 << (i / 4); ppb = 8 / bp;
      cfg_bpp_in <= 6'(bp); cfg_width_in <= 12'h7; cfg_height_in <= 12'hb; slow <= i[2];
      pixel_packing_order_in <= i[0]; buffer_scan_order_in <= i[1];
      pkc = i[0] ? 9 : 5; oth = i[0] ? 5 : 9;
      if (i[0] == i[1]) a = 32'(oth * (((i[0] ? 11 : 7) + ppb - 1) / ppb) + pkc / ppb);
      else a = 32'((pkc / ppb) * (i[0] ? 7 : 11) + oth);
      a = a + 32'h40; sh = (pkc % ppb) * bp;
      s = (i[0] == i[1]) ? ((i[0] ? 11 : 7) + ppb - 1) / ppb : (i[0] ? 7 : 11);
      c = 32'(i * 5 + 3) & 32'((1 << bp) - 1);
      e = (mem.mem_r[a[7:0]] & ~8'(((1 << bp) - 1) << sh)) | 8'(c << sh);
      do_req(1'b1, 12'h5, 12'h9, c, rc, er);
      chk("packed byte", 32'(e), 32'(mem.mem_r[a[7:0]]));
      chk("packed stride", 32'(s), line_stride_out);
      do_req(1'b0, 12'h5, 12'h9, 32'h0, rc, er);
      chk("narrow read", c, rc);
      chk("read error flag", 32'h0, 32'(er));
    end
  endtask : t_narrow
  // refused requests leave memory alone
  task t_refuse;
    logic [31:0] rc; logic er; logic [23:0] keep, seen;
    keep = {mem.mem_r[8'h10], mem.mem_r[8'h15], mem.mem_r[8'h24]};
    cfg_bpp_in <= 6'h03; cfg_width_in <= 12'h5; cfg_height_in <= 12'h4; cfg_base_in <= 32'h10;
    do_req(1'b1, 12'h0, 12'h0, 32'hff, rc, er);
    chk("bad depth refused", 32'h1, 32'(er));
    cfg_bpp_in <= 6'h08;
    do_req(1'b1, 12'h5, 12'h0, 32'hff, rc, er);
    chk("x beyond width", 32'h1, 32'(er));
    do_req(1'b1, 12'h0, 12'h4, 32'hff, rc, er);
    chk("y beyond height", 32'h1, 32'(er));
    seen = {mem.mem_r[8'h10], mem.mem_r[8'h15], mem.mem_r[8'h24]};
    chk("memory untouched", 32'(keep), 32'(seen));
  endtask : t_refuse
  // reset for six cycles, then the scenarios back to back
  initial begin
    repeat (6) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    chk("ready after reset", 32'h1, 32'(req_ready_out));
    chk("quiet after reset", 32'h0, 32'({rsp_valid_out, rsp_error_out, mem_req_out, mem_we_out}));
    t_wide;
    t_narrow;
    t_refuse;
    results;
  end
endmodule : test_frame_buffer_pixel_packer
`default_nettype wire

// ---- logic/fbp_frame_buffer_pixel_packer.sv ----
// Summary of operation
// - row packing below 8 bpp: row neighbours share a byte, rows padded to bytes
// - column packing below 8 bpp: column neighbours share a byte, columns padded
// - pixel 0 at byte LSBs; 2, 4 or 8 pixels per byte at depth 4, 2, 1
// - depth 8 and up: row-major from top row, 16 bpp x steps by 2
// - 32 bpp: four bytes, least significant first, next pixel follows directly
// - 24 bpp: three bytes per pixel, least significant first, no padding
// - 16 bpp: low byte at even address; 8 bpp: one pixel per byte
// - below 8 bpp: byte ordering selectable, row by row or column by column
// - row order, row packing: successive bytes hold successive row groups
// - row order, column packing: byte n holds vertical group of column n
// - column order, row packing: byte n holds horizontal group of row n
// - column order, column packing: successive bytes walk down column 0
// - depths 1, 2, 4, 8, 16, 24 and 32 accepted
`timescale 1ns/1ps
`default_nettype none
module fbp_frame_buffer_pixel_packer (
  input  wire logic                        ref_clk_in,
  input  wire logic                        sys_rst_in,
  input  wire logic [fbp_pkg::BPP_W-1:0]   cfg_bpp_in,
  input  wire logic                        pixel_packing_order_in,
  input  wire logic                        buffer_scan_order_in,
  input  wire logic [fbp_pkg::ADDR_W-1:0]  cfg_base_in,
  input  wire logic [fbp_pkg::COORD_W-1:0] cfg_width_in,
  input  wire logic [fbp_pkg::COORD_W-1:0] cfg_height_in,
  input  wire logic                        req_valid_in,
  input  wire logic                        req_write_in,
  input  wire logic [fbp_pkg::COORD_W-1:0] req_x_in,
  input  wire logic [fbp_pkg::COORD_W-1:0] req_y_in,
  input  wire logic [fbp_pkg::PIX_W-1:0]   req_color_in,
  output logic                             req_ready_out,
  output logic                             rsp_valid_out,
  output logic                             rsp_error_out,
  output logic [fbp_pkg::PIX_W-1:0]        rsp_color_out,
  output logic [fbp_pkg::ADDR_W-1:0]       line_stride_out,
  output logic                             mem_req_out,
  output logic                             mem_we_out,
  output logic [fbp_pkg::ADDR_W-1:0]       mem_addr_out,
  output logic [fbp_pkg::BYTE_W-1:0]       mem_wdata_out,
  input  wire logic                        mem_ack_in,
  input  wire logic [fbp_pkg::BYTE_W-1:0]  mem_rdata_in
);

  // depth decode helpers, shared by address and data paths
  function automatic logic bpp_ok(input logic [fbp_pkg::BPP_W-1:0] b);
    bpp_ok = (b == fbp_pkg::BPP_1) || (b == fbp_pkg::BPP_2) ||
             (b == fbp_pkg::BPP_4) || (b == fbp_pkg::BPP_8) ||
             (b == fbp_pkg::BPP_16) || (b == fbp_pkg::BPP_24) ||
             (b == fbp_pkg::BPP_32);
  endfunction : bpp_ok

  // depths that share one byte among several pixels
  function automatic logic bpp_small(input logic [fbp_pkg::BPP_W-1:0] b);
    bpp_small = (b == fbp_pkg::BPP_1) || (b == fbp_pkg::BPP_2) ||
                (b == fbp_pkg::BPP_4);
  endfunction : bpp_small

  // log2 of depth for 1, 2, 4
  function automatic logic [1:0] bpp_lg(input logic [fbp_pkg::BPP_W-1:0] b);
    case (b)
      fbp_pkg::BPP_2: bpp_lg = 2'h1;
      fbp_pkg::BPP_4: bpp_lg = 2'h2;
      default:        bpp_lg = 2'h0;
    endcase
  endfunction : bpp_lg

  // bytes per pixel minus one for wide depths
  function automatic logic [1:0] bpp_last(input logic [fbp_pkg::BPP_W-1:0] b);
    case (b)
      fbp_pkg::BPP_16: bpp_last = 2'h1;
      fbp_pkg::BPP_24: bpp_last = 2'h2;
      fbp_pkg::BPP_32: bpp_last = 2'h3;
      default:         bpp_last = 2'h0;
    endcase
  endfunction : bpp_last

  // sequencer state
  fbp_pkg::fbp_state_t state_r;
  fbp_pkg::fbp_state_t state_nxt;

  // per-request context and datapath registers
  logic                         small_r;
  logic                         write_r;
  logic                         err_r;
  logic [1:0]                   last_r;
  logic [fbp_pkg::CNT_W-1:0]    cnt_r;
  logic [2:0]                   bitpos_r;
  logic [fbp_pkg::BYTE_W-1:0]   mask_r;
  logic [fbp_pkg::ADDR_W-1:0]   addr_r;
  logic [fbp_pkg::PIX_W-1:0]    color_r;
  logic [fbp_pkg::BYTE_W-1:0]   wbyte_r;
  logic [fbp_pkg::PIX_W-1:0]    rsp_color_r;
  logic [fbp_pkg::ADDR_W-1:0]   stride_r;

  // combinational decode of the current request
  logic                         req_take;
  logic                         req_bad;
  logic                         c_small;
  logic [1:0]                   c_lg;
  logic [1:0]                   c_sh;
  logic [2:0]                   c_bytes;
  logic [fbp_pkg::COORD_W-1:0]  c_pk;
  logic [fbp_pkg::COORD_W-1:0]  c_other;
  logic [fbp_pkg::COORD_W-1:0]  c_extent;
  logic [fbp_pkg::COORD_W-1:0]  c_oextent;
  logic [fbp_pkg::COORD_W-1:0]  c_group;
  logic [2:0]                   c_idx;
  logic [fbp_pkg::ADDR_W-1:0]   c_stride;
  logic [fbp_pkg::ADDR_W-1:0]   c_offset;
  logic [fbp_pkg::BYTE_W-1:0]   c_mask;
  logic [fbp_pkg::BYTE_W-1:0]   rd_field;
  logic [fbp_pkg::BYTE_W-1:0]   merged;
  logic                         beat_last;

  // a request is only taken in idle; a refused one skips memory
  assign req_take = (state_r == fbp_pkg::ST_IDLE) && req_valid_in;
  assign req_bad  = !bpp_ok(cfg_bpp_in) ||
                    (req_x_in >= cfg_width_in) || (req_y_in >= cfg_height_in);

  // coordinate to byte address and bit position; config sampled per request
  always_comb begin
    // depth class and shift amounts
    c_small   = bpp_small(cfg_bpp_in);
    c_lg      = bpp_lg(cfg_bpp_in);
    c_sh      = fbp_pkg::PPB_SH_MAX - {1'b0, c_lg[1]} - {1'b0, c_lg[0]} -
                {1'b0, c_lg[1]};
    // bytes per pixel for the wide path
    c_bytes   = {1'b0, bpp_last(cfg_bpp_in)} + 3'h1;
    // packed axis runs inside the byte, the other axis across bytes
    c_pk      = (pixel_packing_order_in == fbp_pkg::PACK_ROW) ? req_x_in : req_y_in;
    c_other   = (pixel_packing_order_in == fbp_pkg::PACK_ROW) ? req_y_in : req_x_in;
    c_extent  = (pixel_packing_order_in == fbp_pkg::PACK_ROW) ? cfg_width_in : cfg_height_in;
    c_oextent = (pixel_packing_order_in == fbp_pkg::PACK_ROW) ? cfg_height_in : cfg_width_in;
    // byte group along the packed axis and pixel slot inside it
    c_group   = c_pk >> c_sh;
    c_idx     = 3'(c_pk) & ((3'h1 << c_sh) - 3'h1);
    // field mask holds depth ones from bit zero
    c_mask    = (8'h01 << (8'h01 << c_lg)) - 8'h01;

    // address; wide depths ignore the packing and scan settings
    if (!c_small) begin
      // row-major, byte address steps by bytes per pixel
      // trade-off: one wide product per request, kept combinational for latency
      c_stride = 32'(cfg_width_in) * 32'(c_bytes);
      c_offset = 32'(req_y_in) * c_stride + 32'(req_x_in) * 32'(c_bytes);
    end else if (pixel_packing_order_in == buffer_scan_order_in) begin
      // scan follows packed axis: padded line, groups advance along it
      c_stride = 32'((c_extent + ((12'h1 << c_sh) - 12'h1)) >> c_sh);
      c_offset = 32'(c_other) * c_stride + 32'(c_group);
    end else begin
      // scan across packed axis: successive bytes step the other coordinate
      c_stride = 32'(c_oextent);
      c_offset = 32'(c_group) * c_stride + 32'(c_other);
    end
  end

  // read field extraction and merge for sub-byte pixels
  // limitation: read data is trusted only in the ack cycle
  assign rd_field  = (mem_rdata_in >> bitpos_r) & mask_r;
  assign merged    = (mem_rdata_in & ~(mask_r << bitpos_r)) |
                     ((color_r[7:0] & mask_r) << bitpos_r);
  // narrow pixels take one beat per state (read, then write for a write), wide ones one beat per byte
  assign beat_last = small_r || (cnt_r == last_r);

  // request sequencing
  always_comb begin
    // hold state unless a transition below fires
    state_nxt = state_r;
    case (state_r)
      // narrow writes read first so neighbouring pixels survive
      fbp_pkg::ST_IDLE: begin
        if (req_valid_in) begin
          // refused: answer at once, memory left alone
          if (req_bad) begin
            state_nxt = fbp_pkg::ST_RSP;
          end else if (c_small || !req_write_in) begin
            state_nxt = fbp_pkg::ST_RD;
          end else begin
            state_nxt = fbp_pkg::ST_WR;
          end
        end
      end
      // a narrow write turns its read beat into a write beat
      fbp_pkg::ST_RD: begin
        if (mem_ack_in) begin
          if (small_r && write_r) begin
            state_nxt = fbp_pkg::ST_WR;
          end else if (beat_last) begin
            state_nxt = fbp_pkg::ST_RSP;
          end
        end
      end
      // wide writes walk every byte of the pixel
      fbp_pkg::ST_WR: begin
        if (mem_ack_in && beat_last) begin
          state_nxt = fbp_pkg::ST_RSP;
        end
      end
      // response lasts one cycle, ready returns after it
      fbp_pkg::ST_RSP: state_nxt = fbp_pkg::ST_IDLE;
      default:         state_nxt = fbp_pkg::ST_IDLE;
    endcase
  end

  // state register; reset parks the sequencer in idle
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_r <= fbp_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // per-request context, captured once so config changes mid-access are harmless
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      small_r  <= 1'b0;
      write_r  <= 1'b0;
      err_r    <= 1'b0;
      last_r   <= 2'h0;
      bitpos_r <= 3'h0;
      mask_r   <= fbp_pkg::BYTE_RST;
      color_r  <= fbp_pkg::COLOR_RST;
      stride_r <= fbp_pkg::ADDR_RST;
    end else if (req_take) begin
      // depth class, colour and stride frozen for the whole access
      small_r  <= c_small;
      write_r  <= req_write_in;
      err_r    <= req_bad;
      last_r   <= bpp_last(cfg_bpp_in);
      bitpos_r <= c_idx << c_lg;
      mask_r   <= c_mask;
      color_r  <= req_color_in;
      stride_r <= c_stride;
    end
  end

  // byte address and beat count, one byte per acknowledged beat
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      addr_r <= fbp_pkg::ADDR_RST;
      cnt_r  <= 2'h0;
    end else if (req_take) begin
      addr_r <= cfg_base_in + c_offset;
      cnt_r  <= 2'h0;
    end else if (mem_ack_in && !beat_last &&
                 (state_r == fbp_pkg::ST_RD || state_r == fbp_pkg::ST_WR)) begin
      // next byte of a wide pixel sits at the next address
      addr_r <= addr_r + 32'h1;
      cnt_r  <= cnt_r + 2'h1;
    end
  end

  // write byte: lsb first for wide pixels, merged byte for narrow ones
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wbyte_r <= fbp_pkg::BYTE_RST;
    end else if (req_take) begin
      wbyte_r <= req_color_in[7:0];
    end else if (state_r == fbp_pkg::ST_RD && mem_ack_in && small_r) begin
      // narrow write: byte just read with the new field merged in
      wbyte_r <= merged;
    end else if (state_r == fbp_pkg::ST_WR && mem_ack_in && !beat_last) begin
      // wide write: next more significant byte of the pixel
      wbyte_r <= color_r[{cnt_r + 2'h1, 3'h0} +: 8];
    end
  end

  // read assembly, low byte first
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rsp_color_r <= fbp_pkg::COLOR_RST;
    end else if (req_take) begin
      // cleared at take so write responses carry zero
      rsp_color_r <= fbp_pkg::COLOR_RST;
    end else if (state_r == fbp_pkg::ST_RD && mem_ack_in && !write_r) begin
      // narrow read returns the field zero-extended
      if (small_r) begin
        rsp_color_r <= {24'h000000, rd_field};
      end else begin
        rsp_color_r[{cnt_r, 3'h0} +: 8] <= mem_rdata_in;
      end
    end
  end

  // handshake outputs are decoded from state, data from flops
  assign req_ready_out   = (state_r == fbp_pkg::ST_IDLE);
  assign rsp_valid_out   = (state_r == fbp_pkg::ST_RSP);
  assign rsp_error_out   = (state_r == fbp_pkg::ST_RSP) && err_r;

  // data outputs straight from flops
  assign rsp_color_out   = rsp_color_r;
  assign line_stride_out = stride_r;

  // memory side: request held until acknowledged
  assign mem_req_out     = (state_r == fbp_pkg::ST_RD) || (state_r == fbp_pkg::ST_WR);
  assign mem_we_out      = (state_r == fbp_pkg::ST_WR);
  assign mem_addr_out    = addr_r;
  assign mem_wdata_out   = wbyte_r;

endmodule : fbp_frame_buffer_pixel_packer
`default_nettype wire

// ---- logic/fbp_pkg.sv ----
`default_nettype none
package fbp_pkg;

  // datapath widths
  localparam int COORD_W = 12;
  localparam int ADDR_W  = 32;
  localparam int PIX_W   = 32;
  localparam int BYTE_W  = 8;
  localparam int BPP_W   = 6;
  localparam int CNT_W   = 2;

  // accepted bits-per-pixel values
  localparam logic [BPP_W-1:0] BPP_1  = 6'h01;
  localparam logic [BPP_W-1:0] BPP_2  = 6'h02;
  localparam logic [BPP_W-1:0] BPP_4  = 6'h04;
  localparam logic [BPP_W-1:0] BPP_8  = 6'h08;
  localparam logic [BPP_W-1:0] BPP_16 = 6'h10;
  localparam logic [BPP_W-1:0] BPP_24 = 6'h18;
  localparam logic [BPP_W-1:0] BPP_32 = 6'h20;

  // packing of pixels inside one byte (depths below eight)
  localparam logic PACK_ROW = 1'b0;
  localparam logic PACK_COL = 1'b1;

  // ordering of bytes across the buffer (depths below eight)
  localparam logic SCAN_ROW = 1'b0;
  localparam logic SCAN_COL = 1'b1;

  // log2 of pixels per byte at depth one
  localparam logic [1:0] PPB_SH_MAX = 2'h3;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST  = 32'h0000_0000;
  localparam logic [PIX_W-1:0]  COLOR_RST = 32'h0000_0000;
  localparam logic [BYTE_W-1:0] BYTE_RST  = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RD,
    ST_WR,
    ST_RSP
  } fbp_state_t;

endpackage : fbp_pkg
`default_nettype wire
